//--- src/hrs_reset_seq.sv
// hub reset and strap configuration sequencer, top level
// assumes pins arrive asynchronously; hub logic handshakes sit on i_clk
//
// Overview of operation
// - all three config straps zero selects built-in defaults and strap sampling.
// - bits not controlled by a strap take their built-in default value.
// - a strap pin pulled high reads one, pulled low reads zero.
// - led strap high means led driven active low, low means active high.
// - led straps sampled after reset release, applied only in default mode.
// - hardware reset disables ports and removes port power unless charging enabled.
// - hardware reset disables transceivers, differential pairs go high impedance.
// - hardware reset aborts every transaction at once, no state kept.
// - hardware reset returns all internal registers to defaults, mostly zero.
// - oscillator and pll are stopped while hardware reset is asserted.
// - operational within 500 us of release, then eeprom read starts at once.
// - in strap mode outputs reach inactive states within 2 us of release.
// - eeprom load takes at most 99.5 ms, attach follows within 100 ms.
// - self-powered smbus setups have no load limit; device waits as long as needed.
// - each standard request completes within 5 ms.
// - usb bus reset sets address to zero and unconfigured state.
// - usb bus reset removes port power unless charging is enabled.
// - usb bus reset clears transaction buffers and leaves suspend.
// - usb bus reset is never forwarded downstream.
// - smbus mode waits without limit, attaches only after the load.
// - attach control bit signals attach and write-protects configuration memory (write-protect set in smbus mode only).
`timescale 1ns/1ps
`default_nettype none
module hrs_reset_seq #(
  parameter int PORTS        = 4,
  parameter int FIXED        = 2,
  parameter int RECOVER_CYC  = hrs_pkg::RECOVER_CYC,
  parameter int EE_LOAD_CYC  = hrs_pkg::EE_LOAD_CYC,
  parameter int SMB_LOAD_CYC = hrs_pkg::SMB_LOAD_CYC,
  parameter int REQ_CYC      = hrs_pkg::REQ_CYC
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  // pins
  input  wire logic             i_reset_pin_n,
  input  wire logic [2:0]       i_cfg_sel,
  input  wire logic [FIXED-1:0] i_fixed_device_straps,
  input  wire logic [PORTS-1:0] i_port_led_straps,
  input  wire logic             i_charging_port_enable,
  input  wire logic             i_self_powered,
  // hub core handshakes
  input  wire logic             i_ee_done,
  input  wire logic             i_smb_attach,
  input  wire logic             i_usb_bus_reset,
  input  wire logic             i_set_addr,
  input  wire logic [6:0]       i_addr,
  input  wire logic             i_set_config,
  input  wire logic             i_suspend,
  input  wire logic             i_req_start,
  input  wire logic             i_req_done,
  input  wire logic [PORTS-1:0] i_port_power_req,
  input  wire logic [PORTS-1:0] i_led_on,
  // outputs
  output logic                  o_osc_en,
  output logic                  o_pll_en,
  output logic                  o_phy_en,
  output logic                  o_txn_abort,
  output logic                  o_regs_default,
  output logic [PORTS-1:0]      o_port_enable,
  output logic [PORTS-1:0]      o_port_power_enable,
  output logic [PORTS-1:0]      o_port_led_out,
  output logic [PORTS-1:0]      o_port_led_oe_n,
  output logic [FIXED-1:0]      o_fixed_device,
  output logic                  o_outputs_active,
  output logic                  o_ee_start,
  output logic                  o_ee_timeout,
  output logic                  o_smb_late,
  output logic                  o_cfg_apply,
  output logic                  o_attach,
  output logic                  o_cfg_write_protect,
  output logic [6:0]            o_dev_addr,
  output logic                  o_configured,
  output logic                  o_suspended,
  output logic                  o_tt_clear,
  output logic                  o_req_force_done
);
  localparam int W = hrs_pkg::TMR_W;

  initial begin
    if (PORTS < 1 || FIXED < 1)
      $error("port and strap counts must be at least one");
    if (RECOVER_CYC < 1 || EE_LOAD_CYC < 1 || SMB_LOAD_CYC < 1 || REQ_CYC < 1)
      $error("timing counts must be at least one cycle");
    if (RECOVER_CYC >= 2**W || EE_LOAD_CYC >= 2**W || SMB_LOAD_CYC >= 2**W || REQ_CYC >= 2**W)
      $error("timing count too wide for the timer");
  end

  // two-flop synchronisers for every pin; first stage read only by the second
  localparam int SW = 3 + FIXED + PORTS + 3;
  logic [SW-1:0] pin_meta_q;
  logic [SW-1:0] pin_sync_q;
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      pin_meta_q <= {i_reset_pin_n, i_charging_port_enable, i_self_powered,
                     i_cfg_sel, i_fixed_device_straps, i_port_led_straps};
      pin_sync_q <= pin_meta_q;
    end
  end

  logic             rst_pin_n_s;
  logic             charge_s;
  logic             self_pwr_s;
  logic [2:0]       cfg_s;
  logic [FIXED-1:0] fixed_s;
  logic [PORTS-1:0] led_s;
  assign {rst_pin_n_s, charge_s, self_pwr_s, cfg_s, fixed_s, led_s} = pin_sync_q;

  // hardware reset: core reset or the synchronised reset pin held low
  logic hw_rst;
  assign hw_rst = i_rst || !rst_pin_n_s;

  hrs_pkg::hrs_state_t state_q;
  logic [7:0]          since_q;    // cycles since release, saturating
  logic                tmr_load;
  logic [W-1:0]        tmr_count;
  logic                tmr_exp;
  logic                req_busy_q;
  logic                req_exp;

  hrs_strap_if #(.PORTS(PORTS), .FIXED(FIXED)) st ();

  assign st.clear     = hw_rst;
  assign st.cfg_raw   = cfg_s;
  assign st.fixed_raw = fixed_s;
  assign st.led_raw   = led_s;
  // sample just past the strap hold time after release
  assign st.sample    = (state_q == hrs_pkg::ST_RECOVER)
                        && (since_q == 8'(hrs_pkg::STRAP_SAMPLE_CYC));

  hrs_strap_capture u_cap (
    .i_clk (i_clk),
    .i_ce  (i_ce),
    .st    (st)
  );

  hrs_timer #(.W(W)) u_seq_tmr (
    .i_clk     (i_clk),
    .i_ce      (i_ce),
    .i_load    (tmr_load),
    .i_count   (tmr_count),
    .o_expired (tmr_exp)
  );

  hrs_timer #(.W(W)) u_req_tmr (
    .i_clk     (i_clk),
    .i_ce      (i_ce),
    .i_load    (i_req_start),
    .i_count   (W'(REQ_CYC)),
    .o_expired (req_exp)
  );

  // timer loads on entry to each timed state
  always_comb begin
    tmr_load  = 1'b0;
    tmr_count = '0;
    case (state_q)
      hrs_pkg::ST_HWRST: begin
        tmr_load  = !hw_rst;
        tmr_count = W'(RECOVER_CYC);
      end
      hrs_pkg::ST_RECOVER: begin
        tmr_load  = tmr_exp && st.valid && !st.default_mode;
        tmr_count = st.smbus_mode ? W'(SMB_LOAD_CYC) : W'(EE_LOAD_CYC);
      end
      default: begin
        tmr_load  = 1'b0;
        tmr_count = '0;
      end
    endcase
  end

  // start-up sequence; hardware reset drops every state at once
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (hw_rst) begin
        state_q <= hrs_pkg::ST_HWRST;
      end else begin
        case (state_q)
          hrs_pkg::ST_HWRST:
            state_q <= hrs_pkg::ST_RECOVER;
          hrs_pkg::ST_RECOVER:
            if (tmr_exp && st.valid) begin
              if (st.default_mode)
                state_q <= hrs_pkg::ST_CONFIG;
              else if (st.smbus_mode)
                state_q <= hrs_pkg::ST_SMB_WAIT;
              else
                state_q <= hrs_pkg::ST_EE_LOAD;
            end
          hrs_pkg::ST_EE_LOAD:
            if (i_ee_done || tmr_exp)
              state_q <= hrs_pkg::ST_CONFIG;
          hrs_pkg::ST_SMB_WAIT:
            if (i_smb_attach)
              state_q <= hrs_pkg::ST_CONFIG;
          hrs_pkg::ST_CONFIG:
            state_q <= hrs_pkg::ST_RUN;
          hrs_pkg::ST_RUN:
            state_q <= hrs_pkg::ST_RUN;
          default:
            state_q <= hrs_pkg::ST_HWRST;
        endcase
      end
    end
  end

  // cycles since release, for strap sampling and inactive-output timing
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (hw_rst)
        since_q <= 8'h00;
      else if (since_q != 8'hFF)
        since_q <= since_q + 8'h01;
    end
  end

  // clocks, transceivers, aborts and default load follow hardware reset
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      o_osc_en       <= !hw_rst;
      o_pll_en       <= !hw_rst;
      o_phy_en       <= !hw_rst && (state_q == hrs_pkg::ST_RUN);
      o_txn_abort    <= hw_rst;
      o_regs_default <= hw_rst;
    end
  end

  // outputs go inactive well inside the limit: one cycle after sampling
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (hw_rst)
        o_outputs_active <= 1'b0;
      else if (st.valid && since_q <= 8'(hrs_pkg::INACTIVE_CYC))
        o_outputs_active <= 1'b1;
    end
  end

  // led pins: released in reset so the strap can be read, then driven
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (hw_rst || !st.valid) begin
        o_port_led_oe_n <= '1;
        o_port_led_out  <= '0;
      end else begin
        o_port_led_oe_n <= '0;
        // a high strap inverts the drive: lit means low
        o_port_led_out  <= i_led_on ^ st.led_q;
      end
      o_fixed_device <= st.fixed_q;
    end
  end

  // sequencer pulses and sticky timing flags
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (hw_rst) begin
        o_ee_start   <= 1'b0;
        o_ee_timeout <= 1'b0;
        o_smb_late   <= 1'b0;
        o_cfg_apply  <= 1'b0;
      end else begin
        o_ee_start  <= tmr_load && (state_q == hrs_pkg::ST_RECOVER) && !st.smbus_mode;
        o_cfg_apply <= (state_q == hrs_pkg::ST_CONFIG);
        if (state_q == hrs_pkg::ST_EE_LOAD && tmr_exp && !i_ee_done)
          o_ee_timeout <= 1'b1;
        // self-powered hubs have no load limit; only bus-powered ones flag it
        if (state_q == hrs_pkg::ST_SMB_WAIT && tmr_exp && !self_pwr_s)
          o_smb_late <= 1'b1;
      end
    end
  end

  // attach and write-protect follow the configured state
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (hw_rst) begin
        o_attach            <= 1'b0;
        o_cfg_write_protect <= 1'b0;
      end else if (state_q == hrs_pkg::ST_CONFIG) begin
        o_attach            <= 1'b1;
        o_cfg_write_protect <= st.smbus_mode;
      end
    end
  end

  // usb-level state; a bus reset only touches upstream-facing state
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (hw_rst) begin
        o_dev_addr   <= hrs_pkg::ADDR_RESET;
        o_configured <= 1'b0;
        o_suspended  <= 1'b0;
        o_tt_clear   <= 1'b0;
      end else if (i_usb_bus_reset) begin
        o_dev_addr   <= hrs_pkg::ADDR_RESET;
        o_configured <= 1'b0;
        o_suspended  <= 1'b0;
        o_tt_clear   <= 1'b1;
      end else begin
        o_tt_clear <= 1'b0;
        if (i_set_addr && state_q == hrs_pkg::ST_RUN)
          o_dev_addr <= i_addr;
        if (i_set_config && state_q == hrs_pkg::ST_RUN)
          o_configured <= 1'b1;
        o_suspended <= i_suspend && state_q == hrs_pkg::ST_RUN;
      end
    end
  end

  // downstream ports: no bus reset is passed on, only power is cut unless charging is enabled
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (hw_rst) begin
        o_port_enable       <= '0;
        o_port_power_enable <= charge_s ? '1 : '0;
      end else if (i_usb_bus_reset) begin
        o_port_enable       <= o_port_enable;
        o_port_power_enable <= charge_s ? o_port_power_enable : '0;
      end else if (state_q == hrs_pkg::ST_RUN) begin
        o_port_enable       <= '1;
        o_port_power_enable <= i_port_power_req | (charge_s ? o_port_power_enable : '0);
      end
    end
  end

  // request watchdog forces completion one cycle after the time limit
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (hw_rst || i_usb_bus_reset) begin
        req_busy_q       <= 1'b0;
        o_req_force_done <= 1'b0;
      end else begin
        o_req_force_done <= req_busy_q && req_exp && !i_req_done;
        if (i_req_start)
          req_busy_q <= 1'b1;
        else if (i_req_done || req_exp)
          req_busy_q <= 1'b0;
      end
    end
  end
endmodule : hrs_reset_seq
`default_nettype wire

//--- src/hrs_pkg.sv
// constants for the hub reset and strap configuration sequencer
// assumes a single 100 MHz core clock; long counts are overridable at the top
package hrs_pkg;
  // clock
  localparam int  CLK_PERIOD_NS = 10;
  // configuration-select strap encodings
  localparam logic [2:0] CFG_DEFAULT = 3'h0;
  localparam logic [2:0] CFG_SMBUS   = 3'h1;
  // timing figures in their own units
  localparam real STRAP_HOLD_NS   = 16.7;
  localparam int  INACTIVE_MAX_US = 2;
  localparam int  RECOVER_MAX_US  = 500;
  localparam real EE_LOAD_MAX_MS  = 99.5;
  localparam int  SMB_LOAD_MAX_MS = 300;
  localparam int  REQ_MAX_MS      = 5;
  // derived cycle counts: least times round up, longest round down
  localparam int  STRAP_SAMPLE_CYC = int'($ceil(STRAP_HOLD_NS / CLK_PERIOD_NS));
  localparam int  INACTIVE_CYC     = (INACTIVE_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int  RECOVER_CYC      = (RECOVER_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int  EE_LOAD_CYC      = int'($floor(EE_LOAD_MAX_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int  SMB_LOAD_CYC     = (SMB_LOAD_MAX_MS * 1000000) / CLK_PERIOD_NS;
  localparam int  REQ_CYC          = (REQ_MAX_MS * 1000000) / CLK_PERIOD_NS;
  localparam int  TMR_W            = 25;
  // reset values
  localparam logic [6:0] ADDR_RESET = 7'h00;
  // sequencer states
  typedef enum logic [2:0] {
    ST_HWRST, ST_RECOVER, ST_EE_LOAD, ST_SMB_WAIT, ST_CONFIG, ST_RUN
  } hrs_state_t;
endpackage : hrs_pkg

//--- src/hrs_strap_if.sv
// carrier between the sequencer and the strap capture block
// assumes all members are on i_clk and the pins are already synchronised
`timescale 1ns/1ps
`default_nettype none
interface hrs_strap_if #(parameter int PORTS = 4, parameter int FIXED = 2);
  logic             sample;
  logic             clear;
  logic [2:0]       cfg_raw;
  logic [FIXED-1:0] fixed_raw;
  logic [PORTS-1:0] led_raw;
  logic             valid;
  logic             default_mode;
  logic             smbus_mode;
  logic [FIXED-1:0] fixed_q;
  logic [PORTS-1:0] led_q;
  modport cap (input sample, clear, cfg_raw, fixed_raw, led_raw,
               output valid, default_mode, smbus_mode, fixed_q, led_q);
  modport seq (output sample, clear, cfg_raw, fixed_raw, led_raw,
               input valid, default_mode, smbus_mode, fixed_q, led_q);
endinterface : hrs_strap_if
`default_nettype wire

//--- src/hrs_strap_capture.sv
// latches configuration straps once per hardware reset
// assumes sample is a pulse after reset release and clear covers reset
`timescale 1ns/1ps
`default_nettype none
module hrs_strap_capture (
  input  wire logic  i_clk,
  input  wire logic  i_ce,
  hrs_strap_if.cap   st
);
  logic [2:0] cfg_q;
  logic       valid_q;
  logic [$bits(st.fixed_q)-1:0] fixed_q;
  logic [$bits(st.led_q)-1:0]   led_q;

  // first sample after release wins; later samples ignored until next reset
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (st.clear) begin
        valid_q <= 1'b0;
        cfg_q   <= 3'h0;
        fixed_q <= '0;
        led_q   <= '0;
      end else if (st.sample && !valid_q) begin
        valid_q <= 1'b1;
        cfg_q   <= st.cfg_raw;
        fixed_q <= st.fixed_raw;
        led_q   <= st.led_raw;
      end
    end
  end

  assign st.valid        = valid_q;
  assign st.default_mode = valid_q && (cfg_q == hrs_pkg::CFG_DEFAULT);
  assign st.smbus_mode   = valid_q && (cfg_q == hrs_pkg::CFG_SMBUS);
  // outside default mode the strap values do not apply: defaults are zero
  assign st.fixed_q = st.default_mode ? fixed_q : '0;
  assign st.led_q   = st.default_mode ? led_q : '0;
endmodule : hrs_strap_capture
`default_nettype wire

//--- src/hrs_timer.sv
// down counter: load a count, expired rises when it reaches zero
// assumes load and count come from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module hrs_timer #(
  parameter int W = 25
) (
  input  wire logic         i_clk,
  input  wire logic         i_ce,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  output logic              o_expired
);
  logic [W-1:0] cnt_q;

  // reload has priority so a restart in the expiry cycle is not missed
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (i_load) begin
        cnt_q <= i_count;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - W'(1);
      end
    end
  end

  // expiry ignores load: the sequencer reloads off expiry, so gating it would loop
  assign o_expired = (cnt_q == '0);
endmodule : hrs_timer
`default_nettype wire

//--- bench/hrs_reset_seq_properties.sv
// port checker for the reset sequencer
// assumes it is bound onto hrs_reset_seq and sees its ports only
`timescale 1ns/1ps
`default_nettype none
module hrs_reset_seq_properties #(
  parameter int PORTS = 4,
  parameter int FIXED = 2
) (
  input wire logic             i_clk,
  input wire logic             i_rst,
  input wire logic             i_reset_pin_n,
  input wire logic             i_charging_port_enable,
  input wire logic             i_usb_bus_reset,
  input wire logic             o_osc_en,
  input wire logic             o_pll_en,
  input wire logic             o_phy_en,
  input wire logic             o_txn_abort,
  input wire logic             o_regs_default,
  input wire logic [PORTS-1:0] o_port_enable,
  input wire logic [PORTS-1:0] o_port_power_enable,
  input wire logic [FIXED-1:0] o_fixed_device,
  input wire logic             o_outputs_active,
  input wire logic             o_ee_start,
  input wire logic             o_attach,
  input wire logic [6:0]       o_dev_addr,
  input wire logic             o_configured,
  input wire logic             o_suspended,
  input wire logic             o_tt_clear,
  input wire logic             o_req_force_done
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // pin reset needs two sync stages plus one register stage
  chk_osc_halt: assert property ((!i_reset_pin_n)[*4] |-> !o_osc_en && !o_pll_en)
    else $error("clock source running in reset");
  chk_phy_off: assert property ((!i_reset_pin_n)[*4] |-> !o_phy_en && o_port_enable == '0)
    else $error("phy or port enabled in reset");
  chk_txn_abort: assert property ((!i_reset_pin_n)[*4] |-> o_txn_abort && o_regs_default)
    else $error("abort or defaults low in reset");
  chk_power_drop: assert property ((!i_reset_pin_n && !i_charging_port_enable)[*4] |-> o_port_power_enable == '0)
    else $error("port power kept in reset");
  // bus reset outcome one edge later
  chk_bus_state: assert property (i_usb_bus_reset && o_phy_en |=> o_dev_addr == 7'h00 && !o_configured && !o_suspended && o_tt_clear)
    else $error("usb state kept over bus reset");
  chk_no_forward: assert property (i_usb_bus_reset && o_phy_en |=> $stable(o_port_enable))
    else $error("bus reset reached downstream ports");
  chk_bus_power: assert property (i_usb_bus_reset && o_phy_en && !i_charging_port_enable
      && !$past(i_charging_port_enable) && !$past(i_charging_port_enable, 2) |=> o_port_power_enable == '0)
    else $error("port power kept over bus reset");
  chk_attach_hold: assert property (o_attach && i_reset_pin_n |=> o_attach)
    else $error("attach dropped without reset");
  chk_straps_held: assert property (o_outputs_active && $past(o_outputs_active) && i_reset_pin_n |=> $stable(o_fixed_device))
    else $error("captured strap changed");
  chk_force_pulse: assert property (o_req_force_done |=> !o_req_force_done)
    else $error("force done longer than one cycle");
  chk_ee_pulse: assert property (o_ee_start |=> !o_ee_start)
    else $error("eeprom start longer than one cycle");
  cover property ($rose(o_attach));
  cover property (i_usb_bus_reset && o_phy_en);
  cover property (o_req_force_done);
  cover property (o_ee_start);
endmodule : hrs_reset_seq_properties
bind hrs_reset_seq hrs_reset_seq_properties #(.PORTS(PORTS), .FIXED(FIXED)) u_chk (
  .i_clk, .i_rst, .i_reset_pin_n, .i_charging_port_enable, .i_usb_bus_reset, .o_osc_en, .o_pll_en,
  .o_phy_en, .o_txn_abort, .o_regs_default, .o_port_enable, .o_port_power_enable, .o_fixed_device,
  .o_outputs_active, .o_ee_start, .o_attach, .o_dev_addr, .o_configured, .o_suspended, .o_tt_clear,
  .o_req_force_done);
`default_nettype wire

//--- bench/hrs_host_model.sv
// upstream host and configuration source model
// assumes the device handshakes on i_clk; delays are in core cycles
`timescale 1ns/1ps
`default_nettype none
module hrs_host_model #(
  parameter int EE_DLY  = 10,
  parameter int SMB_DLY = 15,
  parameter int ACK_DLY = 100
) (
  input  wire logic i_clk,
  input  wire logic i_ee_start,
  input  wire logic i_attach,
  input  wire logic i_ee_ok,
  input  wire logic i_smb_go,
  output logic      o_ee_done,
  output logic      o_smb_attach,
  output logic      o_usb_bus_reset
);
  int ee_cnt  = 0;
  int smb_cnt = 0;
  int ack_cnt = 0;
  initial begin
    o_ee_done = 1'b0;
    o_smb_attach = 1'b0;
    o_usb_bus_reset = 1'b0;
  end
  // eeprom answers a load start after a delay, or never when broken
  always @(posedge i_clk) begin
    ee_cnt <= i_ee_start ? EE_DLY : (ee_cnt > 0 ? ee_cnt - 1 : 0);
    o_ee_done <= i_ee_ok && ee_cnt == 1;
  end
  // smbus host sets attach when its load ends, with no deadline
  always @(posedge i_clk) begin
    smb_cnt <= i_smb_go ? smb_cnt + 1 : 0;
    o_smb_attach <= i_smb_go && smb_cnt >= SMB_DLY;
  end
  // host waits after attach before a two-cycle bus reset
  always @(posedge i_clk) begin
    ack_cnt <= i_attach ? ack_cnt + 1 : 0;
    o_usb_bus_reset <= i_attach && ack_cnt >= ACK_DLY && ack_cnt < ACK_DLY + 2;
  end
endmodule : hrs_host_model
`default_nettype wire

//--- bench/tb_hrs_reset_seq.sv
// self-checking bench for the reset sequencer
// assumes the host model answers handshakes; long counts are shortened
`timescale 1ns/1ps
`default_nettype none
module tb_hrs_reset_seq;
  localparam int RC = 20, EC = 50, SC = 50, QC = 30;
  logic i_clk = 0, i_rst = 1, i_ce = 1, i_reset_pin_n = 1, i_charging_port_enable = 0, i_self_powered = 0;
  logic [2:0] i_cfg_sel = 3'h0;
  logic [1:0] i_fixed_device_straps = 2'h0, o_fixed_device;
  logic [3:0] i_port_led_straps = 4'h0, i_port_power_req = 4'hF, i_led_on = 4'h3;
  logic [3:0] o_port_enable, o_port_power_enable, o_port_led_out, o_port_led_oe_n;
  logic i_ee_done, i_smb_attach, i_usb_bus_reset, i_set_addr = 0, i_set_config = 0, i_suspend = 0;
  logic i_req_start = 0, i_req_done = 0, ee_ok = 1, smb_go = 0;
  logic [6:0] i_addr = 7'h2A, o_dev_addr;
  logic o_osc_en, o_pll_en, o_phy_en, o_txn_abort, o_regs_default, o_outputs_active, o_ee_start;
  logic o_ee_timeout, o_smb_late, o_cfg_apply, o_attach, o_cfg_write_protect, o_configured;
  logic o_suspended, o_tt_clear, o_req_force_done;
  int errors = 0, n_tests = 0;
  hrs_reset_seq #(.RECOVER_CYC(RC), .EE_LOAD_CYC(EC), .SMB_LOAD_CYC(SC), .REQ_CYC(QC)) DUT (.*);
  hrs_host_model u_host (.i_clk, .i_ee_start(o_ee_start), .i_attach(o_attach), .i_ee_ok(ee_ok),
    .i_smb_go(smb_go), .o_ee_done(i_ee_done), .o_smb_attach(i_smb_attach), .o_usb_bus_reset(i_usb_bus_reset));
  always #5 i_clk = ~i_clk;
  task automatic tk(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tk
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  // bounded wait, n is the cycle count spent
  task automatic wt(ref logic s, input int lim, output int n);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      tk(1);
      n++;
    end
  endtask : wt
  task automatic rst(logic [2:0] c);
    i_cfg_sel = c;
    i_reset_pin_n = 0;
    tk(100);
    i_reset_pin_n = 1;
  endtask : rst
  task automatic t_hw;
    for (int k = 0; k < 2; k++) begin
      i_charging_port_enable = k[0];
      tk(3);
      if (k == 0)
        i_rst = 1;
      else
        i_reset_pin_n = 0;
      tk(100);
      chk({o_osc_en, o_pll_en, o_phy_en, o_attach}, 0);
      chk({o_txn_abort, o_regs_default}, 2'h3);
      chk(o_port_enable, 0);
      chk(o_port_power_enable, k ? 4'hF : 4'h0);
      chk({o_port_led_oe_n, o_dev_addr}, {4'hF, 7'h00});
      i_rst = 0;
      i_reset_pin_n = 1;
    end
    i_charging_port_enable = 0;
  endtask : t_hw
  task automatic t_def;
    int n;
    i_fixed_device_straps = 2'h2;
    i_port_led_straps = 4'h5;
    rst(3'h0);
    wt(o_outputs_active, 200, n);
    chk(n < 200, 1);
    chk(o_fixed_device, 2'h2);
    i_fixed_device_straps = 2'h1;
    i_port_led_straps = 4'hA;
    tk(5);
    chk(o_port_led_oe_n, 0);
    chk(o_port_led_out, 4'h6);
    chk(o_fixed_device, 2'h2);
    wt(o_attach, RC + 20, n);
    chk({n < RC + 20, o_cfg_apply}, 2'h3);
    tk(2);
    chk({o_phy_en, o_port_enable, o_cfg_apply}, 6'h3E);
  endtask : t_def
  // usb state set, then the host's bus reset clears it
  task automatic t_bus;
    int n;
    i_set_addr = 1;
    i_set_config = 1;
    i_suspend = 1;
    tk(1);
    i_set_addr = 0;
    i_set_config = 0;
    tk(2);
    chk({o_dev_addr, o_configured, o_suspended}, {7'h2A, 2'h3});
    wt(o_tt_clear, 200, n);
    chk({o_dev_addr, o_configured, o_suspended, o_port_enable}, {9'h000, 4'hF});
    chk(o_port_power_enable, 0);
    i_suspend = 0;
  endtask : t_bus
  // good load, then a source that never finishes
  task automatic t_ee;
    int n;
    for (int k = 0; k < 2; k++) begin
      ee_ok = (k == 0);
      rst(3'h2);
      wt(o_ee_start, RC + 20, n);
      chk(n < RC + 20, 1);
      wt(o_attach, EC + 20, n);
      chk(n >= (k ? EC - 2 : 8) && n < (k ? EC + 20 : 20), 1);
      chk(o_ee_timeout, k[0]);
    end
    ee_ok = 1;
  endtask : t_ee
  task automatic t_smb;
    int n;
    for (int k = 0; k < 2; k++) begin
      i_self_powered = (k == 0);
      rst(3'h1);
      tk(RC + SC + 20);
      chk({o_attach, o_smb_late}, {1'b0, k[0]});
      smb_go = 1;
      wt(o_attach, 40, n);
      chk({o_attach, o_cfg_write_protect}, 2'h3);
      smb_go = 0;
    end
  endtask : t_smb
  // unanswered request is forced, answered one is not
  task automatic t_req;
    int n;
    i_req_start = 1;
    tk(1);
    i_req_start = 0;
    // enable low for ten cycles freezes the watchdog, so expiry slips by ten
    i_ce = 0;
    tk(10);
    i_ce = 1;
    wt(o_req_force_done, QC + 10, n);
    chk(n >= QC - 1 && n <= QC + 2, 1);
    tk(1);
    chk(o_req_force_done, 0);
    i_req_start = 1;
    tk(1);
    i_req_start = 0;
    tk(5);
    i_req_done = 1;
    tk(1);
    i_req_done = 0;
    wt(o_req_force_done, QC + 10, n);
    chk(n, QC + 10);
  endtask : t_req
  task automatic results;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  initial begin
    tk(3);
    i_rst = 0;
    t_hw();
    t_def();
    t_bus();
    t_ee();
    t_smb();
    t_req();
    results();
  end
  // whole run is near 1250 cycles
  initial begin
    #200us;
    errors++;
    results();
  end
endmodule : tb_hrs_reset_seq
`default_nettype wire
